// ---- dmp_data_port.sv ----
module dmp_data_port #(
  parameter bit Z_OUT_REGISTERED_OPT = 1'b1
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // Core-side requests
  input  wire dmp_pkg::dmp_req_t xReq,
  input  wire dmp_pkg::dmp_req_t yReq,
  input  wire dmp_pkg::dmp_req_t zReq,
  input  wire logic              extRd,
  input  wire logic              extWr,
  input  wire logic [1:0]        extSrc,
  input  wire logic [1:0]        extDst,
  input  wire logic [15:0]       extWdataIn,
  // Read data returned to the core pipeline
  output logic [15:0]            xRdataCore,
  output logic [15:0]            yRdataCore,
  output logic [15:0]            zRdataCore,
  output logic [15:0]            extRdataCore,
  // X memory
  output logic [15:0]            x_addr,
  output logic                   x_rd_sel,
  output logic                   x_wr_sel,
  output logic [15:0]            x_wdata,
  input  wire logic [15:0]       x_rdata,
  // Y memory
  output logic [15:0]            y_addr,
  output logic                   y_rd_sel,
  output logic                   y_wr_sel,
  output logic [15:0]            y_wdata,
  input  wire logic [15:0]       y_rdata,
  // Z space
  output logic [15:0]            z_addr,
  output logic                   z_rd_sel,
  output logic                   z_wr_sel,
  output logic [15:0]            z_wdata,
  input  wire logic [15:0]       z_rdata,
  // User registers
  output logic                   extreg_rd_sel,
  output logic                   extreg_wr_sel,
  output logic [1:0]             extreg_src_code,
  output logic [1:0]             extreg_dst_code,
  output logic [15:0]            extreg_wdata,
  input  wire logic [15:0]       extreg_rdata
);
  dmp_pkg::dmp_bus_t xBus;
  dmp_pkg::dmp_bus_t yBus;
  dmp_pkg::dmp_state_t zState_r;
  logic              zRdSel_r;
  logic              zWrSel_r;
  logic [15:0]       zAddr_r;
  logic [15:0]       zWdataHold_r;
  logic [15:0]       zWdataOut_r;
  logic              extRdSel_r;
  logic              extWrSel_r;
  logic [1:0]        extSrc_r;
  logic [1:0]        extDst_r;
  logic [15:0]       xRdata_r;
  logic [15:0]       yRdata_r;
  logic [15:0]       zRdata_r;
  logic [15:0]       extRdata_r;

  dmp_xy_port uXPort (
    .mclk (core_clk),
    .rstn (rstn),
    .req  (xReq),
    .bus  (xBus)
  );

  dmp_xy_port uYPort (
    .mclk (core_clk),
    .rstn (rstn),
    .req  (yReq),
    .bus  (yBus)
  );

  // X and Y memory outputs, all straight from flip-flops
  assign x_addr   = xBus.addr;
  assign x_rd_sel = xBus.rdSel;
  assign x_wr_sel = xBus.wrSel;
  assign x_wdata  = xBus.wdata;
  assign y_addr   = yBus.addr;
  assign y_rd_sel = yBus.rdSel;
  assign y_wr_sel = yBus.wrSel;
  assign y_wdata  = yBus.wdata;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      zRdSel_r <= 1'b0;
      zWrSel_r <= 1'b0;
    end else begin
      zRdSel_r <= zReq.rd;
      zWrSel_r <= zReq.wr && !zReq.rd;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      zAddr_r <= dmp_pkg::ADDR_RST;
    end else if (zReq.rd || zReq.wr) begin
      zAddr_r <= zReq.addr;
    end
  end

  // Z port sequencing: write data follows one cycle after the select
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      zState_r <= dmp_pkg::ST_IDLE;
    end else begin
      case (zState_r)
        dmp_pkg::ST_IDLE,
        dmp_pkg::ST_READ,
        dmp_pkg::ST_WRITE: begin
          if (zReq.rd) begin
            zState_r <= dmp_pkg::ST_READ;
          end else if (zReq.wr) begin
            zState_r <= dmp_pkg::ST_WRITE;
          end else begin
            zState_r <= dmp_pkg::ST_IDLE;
          end
        end
        default: begin
          zState_r <= dmp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Holds write data for the cycle after the select
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      zWdataHold_r <= dmp_pkg::DATA_RST;
    end else begin
      if (zReq.wr && !zReq.rd) begin
        zWdataHold_r <= zReq.wdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      zWdataOut_r <= dmp_pkg::DATA_RST;
    end else if (zState_r == dmp_pkg::ST_WRITE) begin
      zWdataOut_r <= zWdataHold_r;
    end
  end

  assign z_wdata  = Z_OUT_REGISTERED_OPT ? zWdataOut_r : zWdataHold_r;
  assign z_addr   = zAddr_r;
  assign z_rd_sel = zRdSel_r;
  assign z_wr_sel = zWrSel_r;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      extSrc_r <= dmp_pkg::EXT_RST;
      extDst_r <= dmp_pkg::EXT_RST;
    end else begin
      if (extRd) begin
        extSrc_r <= extSrc;
      end
      if (extWr) begin
        extDst_r <= extDst;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      extRdSel_r <= 1'b0;
      extWrSel_r <= 1'b0;
    end else begin
      extRdSel_r <= extRd;
      extWrSel_r <= extWr;
    end
  end

  assign extreg_rd_sel   = extRdSel_r;
  assign extreg_wr_sel   = extWrSel_r;
  assign extreg_src_code = extSrc_r;
  assign extreg_dst_code = extDst_r;
  assign extreg_wdata    = extWdataIn;

  // sample read data at edge ending access
  // Z read like X and Y
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      xRdata_r    <= dmp_pkg::DATA_RST;
      yRdata_r    <= dmp_pkg::DATA_RST;
      zRdata_r    <= dmp_pkg::DATA_RST;
      extRdata_r  <= dmp_pkg::DATA_RST;
    end else begin
      if (xBus.rdSel) begin
        xRdata_r <= x_rdata;
      end
      if (yBus.rdSel) begin
        yRdata_r <= y_rdata;
      end
      if (zRdSel_r) begin
        zRdata_r <= z_rdata;
      end
      if (extRdSel_r) begin
        extRdata_r <= extreg_rdata;
      end
    end
  end

  assign xRdataCore   = xRdata_r;
  assign yRdataCore   = yRdata_r;
  assign zRdataCore   = zRdata_r;
  assign extRdataCore = extRdata_r;

  // frozen while clock stops: all outputs except extreg_wdata (wired straight from extWdataIn) are flip-flops
  // on core_clk, so a gated clock holds them without extra logic.

  // Assertions
  property p_zDataLate;
    @(posedge core_clk) disable iff (!rstn)
      z_wr_sel |=> (!Z_OUT_REGISTERED_OPT || z_wdata == $past(zReq.wdata, 2));
  endproperty
  a_zDataLate: assert property (p_zDataLate) else $error("Z data not one cycle late");

  property p_zDataNow;
    @(posedge core_clk) disable iff (!rstn)
      z_wr_sel |-> (Z_OUT_REGISTERED_OPT || z_wdata == $past(zReq.wdata));
  endproperty
  a_zDataNow: assert property (p_zDataNow) else $error("Z data not with select");

  property p_zSel;
    @(posedge core_clk) disable iff (!rstn) zReq.wr && !zReq.rd |=> z_wr_sel && !z_rd_sel;
  endproperty
  a_zSel: assert property (p_zSel) else $error("Z write select missing");

  property p_zAddr;
    @(posedge core_clk) disable iff (!rstn)
      (zReq.rd || zReq.wr) |=> z_addr == $past(zReq.addr);
  endproperty
  a_zAddr: assert property (p_zAddr) else $error("Z address not registered");

  property p_extHold;
    @(posedge core_clk) disable iff (!rstn) !extRd |=> $stable(extreg_src_code);
  endproperty
  a_extHold: assert property (p_extHold) else $error("source code moved unqualified");

  property p_extRd;
    @(posedge core_clk) disable iff (!rstn)
      extRd |=> extreg_rd_sel && extreg_src_code == $past(extSrc);
  endproperty
  a_extRd: assert property (p_extRd) else $error("read select or code wrong");

  property p_extWr;
    @(posedge core_clk) disable iff (!rstn)
      extWr |=> extreg_wr_sel && extreg_dst_code == $past(extDst);
  endproperty
  a_extWr: assert property (p_extWr) else $error("write select or code wrong");

  property p_rstIdle;
    @(posedge core_clk) !rstn |=> !x_rd_sel && !x_wr_sel && !z_rd_sel && !z_wr_sel
      && !y_rd_sel && !y_wr_sel && !extreg_rd_sel && !extreg_wr_sel;
  endproperty
  a_rstIdle: assert property (p_rstIdle) else $error("select active after reset");

  property p_xyAlike;
    @(posedge core_clk) disable iff (!rstn)
      xReq == yReq |=> x_rd_sel == y_rd_sel && x_wr_sel == y_wr_sel;
  endproperty
  a_xyAlike: assert property (p_xyAlike) else $error("X and Y ports differ");

  property p_zRdCapture;
    @(posedge core_clk) disable iff (!rstn) z_rd_sel |=> zRdataCore == $past(z_rdata);
  endproperty
  a_zRdCapture: assert property (p_zRdCapture) else $error("Z read data not taken");

  property p_wdataDirect;
    @(posedge core_clk) extreg_wdata == extWdataIn;
  endproperty
  a_wdataDirect: assert property (p_wdataDirect) else $error("user write data registered");

  property p_zRdSel;
    @(posedge core_clk) disable iff (!rstn)
      zReq.rd |=> z_rd_sel && !z_wr_sel;
  endproperty
  a_zRdSel: assert property (p_zRdSel) else $error("Z read select missing");

  property p_zAddrHold;
    @(posedge core_clk) disable iff (!rstn)
      !zReq.rd && !zReq.wr |=> $stable(z_addr);
  endproperty
  a_zAddrHold: assert property (p_zAddrHold) else $error("Z address moved idle");

  property p_extDstHold;
    @(posedge core_clk) disable iff (!rstn)
      !extWr |=> $stable(extreg_dst_code);
  endproperty
  a_extDstHold: assert property (p_extDstHold) else $error("dest code moved");

  property p_extSelSplit;
    @(posedge core_clk) disable iff (!rstn)
      extRd && !extWr |=> extreg_rd_sel && !extreg_wr_sel;
  endproperty
  a_extSelSplit: assert property (p_extSelSplit) else $error("user selects mixed");

  property p_xRdCapture;
    @(posedge core_clk) disable iff (!rstn)
      x_rd_sel |=> xRdataCore == $past(x_rdata);
  endproperty
  a_xRdCapture: assert property (p_xRdCapture) else $error("X read data not taken");

  property p_extRdCapture;
    @(posedge core_clk) disable iff (!rstn)
      extreg_rd_sel |=> extRdataCore == $past(extreg_rdata);
  endproperty
  a_extRdCapture: assert property (p_extRdCapture) else $error("user data not taken");

  c_zWrRd: cover property (@(posedge core_clk) disable iff (!rstn) z_wr_sel ##1 z_rd_sel);
  c_extWr: cover property (@(posedge core_clk) disable iff (!rstn) extreg_wr_sel);
  c_extRd: cover property (@(posedge core_clk) disable iff (!rstn) extreg_rd_sel);
endmodule : dmp_data_port

// ---- dmp_data_port_tb.sv ----
// Self-checking bench for the data memory port
module dmp_data_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam dmp_pkg::dmp_req_t NOREQ = '0;
  logic              mclk, core_clk, coreRan, rstn, extRd, extWr;
  dmp_pkg::dmp_req_t xReq, yReq, zReq;
  logic [1:0]        extSrc, extDst, extreg_src_code, extreg_dst_code;
  logic [15:0]       extWdataIn, xRdataCore, yRdataCore, zRdataCore, extRdataCore;
  logic [15:0]       x_addr, x_wdata, x_rdata, y_addr, y_wdata, y_rdata;
  logic [15:0]       z_addr, z_wdata, z_rdata, extreg_wdata, extreg_rdata;
  logic              x_rd_sel, x_wr_sel, y_rd_sel, y_wr_sel, z_rd_sel, z_wr_sel;
  logic              extreg_rd_sel, extreg_wr_sel;
  int                n_fail, cmp_count, waits;

  dmp_data_port #(.Z_OUT_REGISTERED_OPT(1'b1)) dmp_data_port_i (
    .core_clk, .rstn, .xReq, .yReq, .zReq, .extRd, .extWr, .extSrc, .extDst,
    .extWdataIn, .xRdataCore, .yRdataCore, .zRdataCore, .extRdataCore,
    .x_addr, .x_rd_sel, .x_wr_sel, .x_wdata, .x_rdata,
    .y_addr, .y_rd_sel, .y_wr_sel, .y_wdata, .y_rdata,
    .z_addr, .z_rd_sel, .z_wr_sel, .z_wdata, .z_rdata,
    .extreg_rd_sel, .extreg_wr_sel, .extreg_src_code, .extreg_dst_code,
    .extreg_wdata, .extreg_rdata);

  dmp_glue_model dmp_glue_model_i (
    .mclk, .core_clk, .coreRan,
    .x_addr, .x_rd_sel, .x_wr_sel, .x_wdata, .x_rdata,
    .y_addr, .y_rd_sel, .y_wr_sel, .y_wdata, .y_rdata,
    .z_addr, .z_rd_sel, .z_wr_sel, .z_wdata, .z_rdata,
    .extreg_rd_sel, .extreg_wr_sel, .extreg_src_code, .extreg_dst_code,
    .extreg_wdata, .extreg_rdata);

  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Counts, verdict and end of run
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // Advance to the falling edge after the next core edge; bounded over wait states
  task automatic cyc();
    waits = 0;
    do begin
      @(negedge mclk);
      waits++;
    end while (coreRan !== 1'b1 && waits < 4);
    if (coreRan !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
  endtask : cyc

  // Selects idle and address buses cleared in reset
  task automatic t_reset();
    chk({x_rd_sel, x_wr_sel, y_rd_sel, y_wr_sel, z_rd_sel, z_wr_sel}, '0);
    chk({extreg_rd_sel, extreg_wr_sel}, '0);
    chk(x_addr | y_addr | z_addr, dmp_pkg::ADDR_RST);
    $display("t_reset done");
  endtask : t_reset

  // Back-to-back X and Y writes, then reads, with a Y write refused by its read
  task automatic t_xy();
    xReq = {1'b0, 1'b1, 16'h0012, 16'hBEEF};
    yReq = {1'b0, 1'b1, 16'h0012, 16'hBEEF};
    cyc();
    chk({x_wr_sel, x_rd_sel, y_wr_sel, y_rd_sel}, 4'hA);
    chk(x_addr, 16'h0012);
    chk(x_wdata, 16'hBEEF);
    xReq = {1'b0, 1'b1, 16'h0034, 16'h1234};
    yReq = {1'b0, 1'b1, 16'h0034, 16'h1234};
    cyc();
    chk({x_wr_sel, y_wr_sel}, 2'b11);
    chk(y_addr, 16'h0034);
    chk(y_wdata, 16'h1234);
    xReq = NOREQ;
    yReq = NOREQ;
    cyc();
    chk({x_wr_sel, y_wr_sel}, 2'b00);
    chk(x_addr, 16'h0034);
    chk(x_wdata, 16'h1234);
    xReq = {1'b1, 1'b0, 16'h0012, 16'h0000};
    yReq = {1'b1, 1'b1, 16'h0012, 16'hDEAD};
    cyc();
    chk({x_rd_sel, x_wr_sel, y_rd_sel, y_wr_sel}, 4'hA);
    chk(y_addr, 16'h0012);
    chk(y_wdata, 16'h1234);
    xReq = NOREQ;
    yReq = NOREQ;
    cyc();
    chk(xRdataCore, 16'hBEEF);
    chk(yRdataCore, 16'hBEEF);
    chk({x_rd_sel, y_rd_sel}, 2'b00);
    $display("t_xy done");
  endtask : t_xy

  // Z write followed at once by a Z read, with one wait state
  task automatic t_z();
    zReq = {1'b0, 1'b1, 16'h0056, 16'hCAFE};
    cyc();
    chk({z_wr_sel, z_rd_sel}, 2'b10);
    chk(z_addr, 16'h0056);
    chk(z_wdata, dmp_pkg::DATA_RST);
    zReq = {1'b1, 1'b0, 16'h0056, 16'h0000};
    cyc();
    chk(z_wdata, 16'hCAFE);
    chk({z_wr_sel, z_rd_sel}, 2'b01);
    zReq = NOREQ;
    @(negedge mclk);
    chk({coreRan, z_rd_sel}, 2'b01);
    chk(z_wdata, 16'hCAFE);
    chk(z_addr, 16'h0056);
    cyc();
    chk(zRdataCore, 16'hCAFE);
    chk(z_rd_sel, 1'b0);
    $display("t_z done");
  endtask : t_z

  // Every user register written, then read back; codes hold afterwards
  task automatic t_ext();
    for (int c = 0; c < 4; c++) begin
      extWr = 1'b1;
      extDst = c[1:0];
      cyc();
      extWr = 1'b0;
      extWdataIn = 16'hA5A0 + 16'(c);
      chk({extreg_wr_sel, extreg_rd_sel, extreg_dst_code}, {2'b10, c[1:0]});
      chk(extreg_wdata, 16'hA5A0 + 16'(c));
      cyc();
    end
    for (int c = 0; c < 4; c++) begin
      extRd = 1'b1;
      extSrc = c[1:0];
      cyc();
      extRd = 1'b0;
      chk({extreg_rd_sel, extreg_wr_sel, extreg_src_code}, {2'b10, c[1:0]});
      cyc();
      chk(extRdataCore, 16'hA5A0 + 16'(c));
    end
    chk({extreg_rd_sel, extreg_src_code, extreg_dst_code}, 5'h0F);
    $display("t_ext done");
  endtask : t_ext

  // Free-running system clock, 50 ns period
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Main sequence
  initial begin
    n_fail = 0;
    cmp_count = 0;
    rstn = 1'b0;
    xReq = NOREQ;
    yReq = NOREQ;
    zReq = NOREQ;
    extRd = 1'b0;
    extWr = 1'b0;
    extSrc = 2'h0;
    extDst = 2'h0;
    extWdataIn = 16'h0000;
    repeat (10) @(negedge mclk);
    t_reset();
    rstn = 1'b1;
    cyc();
    t_xy();
    t_z();
    t_ext();
    wrap_up();
  end
endmodule : dmp_data_port_tb

// ---- dmp_glue_model.sv ----
// Behavioural X, Y and Z memories, four user registers and the clock-gating glue
module dmp_glue_model #(
  parameter bit Z_OUT_REGISTERED_OPT = 1'b1
) (
  input  wire logic        mclk,
  output logic             core_clk,
  output logic             coreRan,
  input  wire logic [15:0] x_addr,
  input  wire logic        x_rd_sel,
  input  wire logic        x_wr_sel,
  input  wire logic [15:0] x_wdata,
  output logic      [15:0] x_rdata,
  input  wire logic [15:0] y_addr,
  input  wire logic        y_rd_sel,
  input  wire logic        y_wr_sel,
  input  wire logic [15:0] y_wdata,
  output logic      [15:0] y_rdata,
  input  wire logic [15:0] z_addr,
  input  wire logic        z_rd_sel,
  input  wire logic        z_wr_sel,
  input  wire logic [15:0] z_wdata,
  output logic      [15:0] z_rdata,
  input  wire logic        extreg_rd_sel,
  input  wire logic        extreg_wr_sel,
  input  wire logic [1:0]  extreg_src_code,
  input  wire logic [1:0]  extreg_dst_code,
  input  wire logic [15:0] extreg_wdata,
  output logic      [15:0] extreg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] xMem    [256];
  logic [15:0] yMem    [256];
  logic [15:0] zMem    [256];
  logic [15:0] userReg [4];
  logic [15:0] xLast = 16'h0000;
  logic [15:0] yLast = 16'h0000;
  logic [15:0] zLast = 16'h0000;
  logic [15:0] eLast = 16'h0000;
  logic        stall = 1'b0;
  logic        zWrD  = 1'b0;
  logic [15:0] zAddrD;

  assign core_clk = mclk & ~stall;

  // halt on overlap, or at once for unregistered data
  always @(negedge mclk) begin
    if (Z_OUT_REGISTERED_OPT) begin
      stall <= zWrD & z_rd_sel & ~stall;
    end else begin
      stall <= z_wr_sel & ~stall;
    end
  end

  // delayed Z write; unregistered data captured while halted
  always @(posedge mclk) begin
    zWrD    <= z_wr_sel & ~stall;
    zAddrD  <= z_addr;
    coreRan <= ~stall;
    if (Z_OUT_REGISTERED_OPT && zWrD) begin
      zMem[zAddrD[7:0]] <= z_wdata;
    end else if (!Z_OUT_REGISTERED_OPT && stall && z_wr_sel) begin
      zMem[z_addr[7:0]] <= z_wdata;
    end
  end

  always @(posedge core_clk) begin
    if (x_wr_sel) begin
      xMem[x_addr[7:0]] <= x_wdata;
    end
    if (y_wr_sel) begin
      yMem[y_addr[7:0]] <= y_wdata;
    end
    if (extreg_wr_sel) begin
      userReg[extreg_dst_code] <= extreg_wdata;
    end
    xLast <= x_rdata;
    yLast <= y_rdata;
    zLast <= z_rdata;
    eLast <= extreg_rdata;
  end

  assign x_rdata      = x_rd_sel ? xMem[x_addr[7:0]] : ~xLast;
  assign y_rdata      = y_rd_sel ? yMem[y_addr[7:0]] : ~yLast;
  assign z_rdata      = z_rd_sel ? zMem[z_addr[7:0]] : ~zLast;
  assign extreg_rdata = extreg_rd_sel ? userReg[extreg_src_code] : ~eLast;
endmodule : dmp_glue_model

// ---- dmp_pkg.sv ----
package dmp_pkg;
  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int EXT_W  = 2;

  // Reset values
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [1:0]  EXT_RST  = 2'h0;

  // External register codes
  localparam logic [1:0] USER_REG_ZERO  = 2'h0;
  localparam logic [1:0] USER_REG_ONE   = 2'h1;
  localparam logic [1:0] USER_REG_TWO   = 2'h2;
  localparam logic [1:0] USER_REG_THREE = 2'h3;

  // Core-side request for one data port
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dmp_req_t;

  // Registered memory-side outputs of one data port
  typedef struct packed {
    logic        rdSel;
    logic        wrSel;
    logic [15:0] addr;
    logic [15:0] wdata;
  } dmp_bus_t;

  // Port sequencing state
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } dmp_state_t;
endpackage : dmp_pkg

// ---- dmp_xy_port.sv ----
// One data memory port; X and Y are two instances of this module
module dmp_xy_port (
  input  wire logic            mclk,
  input  wire logic            rstn,
  input  wire dmp_pkg::dmp_req_t req,
  output dmp_pkg::dmp_bus_t    bus
);
  logic        rdSel_r;
  logic        wrSel_r;
  logic [15:0] addr_r;
  logic [15:0] wdata_r;

  // registered address
  // Address moves only with an access, select and data share the edge
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      addr_r <= dmp_pkg::ADDR_RST;
    end else if (req.rd || req.wr) begin
      addr_r <= req.addr;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdSel_r <= 1'b0;
      wrSel_r <= 1'b0;
    end else begin
      rdSel_r <= req.rd;
      wrSel_r <= req.wr && !req.rd;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wdata_r <= dmp_pkg::DATA_RST;
    end else if (req.wr && !req.rd) begin
      wdata_r <= req.wdata;
    end
  end

  // One flop group per field, so each variable has a single writer
  assign bus = '{rdSel: rdSel_r, wrSel: wrSel_r, addr: addr_r, wdata: wdata_r};

  property p_addrHold;
    @(posedge mclk) disable iff (!rstn)
      !$past(req.rd) && !$past(req.wr) |-> $stable(addr_r);
  endproperty
  a_addrHold: assert property (p_addrHold) else $error("address moved without access");

  property p_wrTrio;
    @(posedge mclk) disable iff (!rstn)
      req.wr && !req.rd |=> wrSel_r && addr_r == $past(req.addr)
        && wdata_r == $past(req.wdata);
  endproperty
  a_wrTrio: assert property (p_wrTrio) else $error("write select, address, data split");

  property p_rdSel;
    @(posedge mclk) disable iff (!rstn) req.rd |=> rdSel_r && !wrSel_r;
  endproperty
  a_rdSel: assert property (p_rdSel) else $error("read select not issued");

  c_xyWrite: cover property (@(posedge mclk) disable iff (!rstn) wrSel_r);
endmodule : dmp_xy_port
